//--- rtl/asam_map.svh
// Purpose: Offsets, field positions, reset values and channel codes of the select/alert-enable bank
// Assumes: Byte-wide registers at their printed offsets
// Notes:   Definitions only
`ifndef ASAM_MAP_SVH
`define ASAM_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ASAM_OFF_SINGLE_SEL   8'h13
`define ASAM_OFF_PAIR_SEL     8'h14
`define ASAM_OFF_FAULT_MASK   8'h15
`define ASAM_OFF_MON_MASK_A   8'h16
`define ASAM_OFF_MON_MASK_B   8'h17
`define ASAM_OFF_MON_MASK_C   8'h18
`define ASAM_OFF_MON_MASK_D   8'h19

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ASAM_RST_SINGLE_SEL   8'hFF
`define ASAM_RST_PAIR_SEL     8'h0F
`define ASAM_RST_FAULT_MASK   8'h00
`define ASAM_RST_MON_MASK     8'h00
`define ASAM_UNMAPPED_DATA    8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ASAM_PAIR_AIN12_BIT   4
`define ASAM_VOLTAGE_IN_A_SEL_BIT    1
`define ASAM_SCALED_SEL_BIT   0
`define ASAM_EN_PIN_IRQ_BIT   7
`define ASAM_EEPROM_IRQ_BIT   6
`define ASAM_SENSE_HI_BIT     5
`define ASAM_SENSE_LO_BIT     4
`define ASAM_SUPPLY_HI_BIT    3
`define ASAM_SUPPLY_LO_BIT    2
`define ASAM_POWER_HI_BIT     1
`define ASAM_POWER_LO_BIT     0
`define ASAM_SCALED_HI_BIT    7
`define ASAM_SCALED_LO_BIT    6
`define ASAM_VOLTAGE_IN_A_HI_BIT     5
`define ASAM_VOLTAGE_IN_A_LO_BIT     4

// ----------------------------------------
// Channel codes
// ----------------------------------------
`define ASAM_CH_AUX_IN_1      5'h00
`define ASAM_CH_AUX_IO_1      5'h04
`define ASAM_CH_SCALED        5'h08
`define ASAM_CH_VOLTAGE_IN_A         5'h09
`define ASAM_CH_PAIR_FIRST    5'h0C
`define ASAM_CH_SENSE         5'h10
`define ASAM_CH_SUPPLY        5'h11
`define ASAM_CH_POWER         5'h12
`define ASAM_NUM_CH           19

`endif

//--- rtl/asam_pkg.sv
// Purpose: Types shared by the select/alert-enable bank
// Assumes: Constants come from asam_map.svh
// Notes:   Types only
package asam_pkg;

	typedef logic [4:0] asam_chan_t;
	typedef logic [7:0] asam_byte_t;
	typedef logic [15:0] asam_meas_t;

	// Gray along idle -> request -> wait
	typedef enum logic [1:0] {
		ASAM_IDLE = 2'b00,
		ASAM_REQ  = 2'b01,
		ASAM_WAIT = 2'b11
	} asam_seq_t;

endpackage

//--- rtl/asam_limit_cmp.sv
// Purpose: Compares one measurement against its upper and lower limits
// Assumes: Unsigned codes; limits supplied by the threshold registers outside
// Notes:   Strictly above / strictly below
`timescale 1ns/1ps
`default_nettype none

module asam_limit_cmp
	import asam_pkg::*;
(
	input  wire asam_meas_t i_value,
	input  wire asam_meas_t i_upper,
	input  wire asam_meas_t i_lower,
	output logic            o_above,
	output logic            o_below
);

	// ----------------------------------------
	// Comparison
	// ----------------------------------------
	always_comb begin
		o_above = (i_value > i_upper);
		o_below = (i_value < i_lower);
	end

endmodule

`default_nettype wire

//--- rtl/asam_regs.sv
// Purpose: ADC input select and alert enable registers with conversion sequencing and alert generation
// Assumes: Register port driven by the serial management logic; all inputs synchronous to i_ref_clk
// Notes:   Pair alert enables live in another block, so pair results raise no alert here
`timescale 1ns/1ps
`default_nettype none
`include "asam_map.svh"

module asam_regs
	import asam_pkg::*;
(
	input  wire logic       i_ref_clk,
	input  wire logic       i_reset_n,
	input  wire logic       i_reg_wr,
	input  wire logic       i_reg_rd,
	input  wire asam_byte_t i_reg_addr,
	input  wire asam_byte_t i_reg_wdata,
	output logic [7:0]      o_reg_rdata,
	output logic [18:0]     o_chan_select,
	output logic            o_conv_req,
	output logic [4:0]      o_conv_chan,
	input  wire logic       i_meas_valid,
	input  wire asam_meas_t i_meas_value,
	input  wire asam_meas_t i_meas_upper,
	input  wire asam_meas_t i_meas_lower,
	input  wire asam_byte_t i_fault_evt,
	input  wire logic       i_enable_n,
	input  wire logic       i_eeprom_written,
	input  wire logic       i_alert_clr,
	output logic            o_alert,
	output logic            o_alert_seen
);

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	asam_byte_t single_sel_ff;
	asam_byte_t pair_sel_ff;
	asam_byte_t fault_mask_ff;
	asam_byte_t mon_a_ff;
	asam_byte_t mon_b_ff;
	asam_byte_t mon_c_ff;
	asam_byte_t mon_d_ff;
	asam_byte_t rdata_ff;
	asam_byte_t nxt_rdata;
	asam_seq_t  seq_ff;
	asam_seq_t  nxt_seq;
	asam_chan_t chan_ff;
	asam_chan_t nxt_chan;
	logic       req_ff;
	logic       alert_ff;
	logic       seen_ff;
	logic       en_prev_ff;
	logic       en_known_ff;
	logic [18:0] sel_mask;
	logic [18:0] sel_mask_ff;
	logic [18:0] hi_en;
	logic [18:0] lo_en;
	logic       above;
	logic       below;
	logic       meas_take;
	logic       thr_hit;
	logic       fault_hit;
	logic       pin_hit;
	logic       eeprom_hit;
	logic       nxt_alert;

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			single_sel_ff <= `ASAM_RST_SINGLE_SEL;
			pair_sel_ff   <= `ASAM_RST_PAIR_SEL;
			fault_mask_ff <= `ASAM_RST_FAULT_MASK;
			mon_a_ff      <= `ASAM_RST_MON_MASK;
			mon_b_ff      <= `ASAM_RST_MON_MASK;
			mon_c_ff      <= `ASAM_RST_MON_MASK;
			mon_d_ff      <= `ASAM_RST_MON_MASK;
		end else if (i_reg_wr) begin
			case (i_reg_addr)
				`ASAM_OFF_SINGLE_SEL: begin
					single_sel_ff <= i_reg_wdata;
				end
				`ASAM_OFF_PAIR_SEL: begin
					pair_sel_ff <= i_reg_wdata;
				end
				`ASAM_OFF_FAULT_MASK: begin
					fault_mask_ff <= i_reg_wdata;
				end
				`ASAM_OFF_MON_MASK_A: begin
					mon_a_ff <= i_reg_wdata;
				end
				`ASAM_OFF_MON_MASK_B: begin
					mon_b_ff <= i_reg_wdata;
				end
				`ASAM_OFF_MON_MASK_C: begin
					mon_c_ff <= i_reg_wdata;
				end
				`ASAM_OFF_MON_MASK_D: begin
					mon_d_ff <= i_reg_wdata;
				end
				default: begin
					mon_d_ff <= mon_d_ff;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Register reads
	// ----------------------------------------
	always_comb begin
		case (i_reg_addr)
			`ASAM_OFF_SINGLE_SEL: nxt_rdata = single_sel_ff;
			`ASAM_OFF_PAIR_SEL:   nxt_rdata = pair_sel_ff;
			`ASAM_OFF_FAULT_MASK: nxt_rdata = fault_mask_ff;
			`ASAM_OFF_MON_MASK_A: nxt_rdata = mon_a_ff;
			`ASAM_OFF_MON_MASK_B: nxt_rdata = mon_b_ff;
			`ASAM_OFF_MON_MASK_C: nxt_rdata = mon_c_ff;
			`ASAM_OFF_MON_MASK_D: nxt_rdata = mon_d_ff;
			default:              nxt_rdata = `ASAM_UNMAPPED_DATA;
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rdata_ff <= `ASAM_UNMAPPED_DATA;
		end else if (i_reg_rd) begin
			rdata_ff <= nxt_rdata;
		end
	end

	// ----------------------------------------
	// Channel select and enable maps
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_aux
			assign sel_mask[gi]     = single_sel_ff[gi];
			assign sel_mask[gi + 4] = single_sel_ff[gi + 4];
			assign sel_mask[gi + 12] = pair_sel_ff[`ASAM_PAIR_AIN12_BIT + gi];
			assign hi_en[gi]        = mon_b_ff[7 - 2 * gi];
			assign lo_en[gi]        = mon_b_ff[6 - 2 * gi];
			assign hi_en[gi + 4]    = mon_c_ff[7 - 2 * gi];
			assign lo_en[gi + 4]    = mon_c_ff[6 - 2 * gi];
			assign hi_en[gi + 12]   = 1'b0;
			assign lo_en[gi + 12]   = 1'b0;
		end
	endgenerate

	assign sel_mask[8]  = pair_sel_ff[`ASAM_SCALED_SEL_BIT];
	assign sel_mask[9]  = pair_sel_ff[`ASAM_VOLTAGE_IN_A_SEL_BIT];
	assign sel_mask[10] = 1'b0;
	assign sel_mask[11] = 1'b0;
	assign sel_mask[16] = 1'b1;
	assign sel_mask[17] = 1'b1;
	assign sel_mask[18] = 1'b1;

	assign hi_en[8]  = mon_d_ff[`ASAM_SCALED_HI_BIT];
	assign lo_en[8]  = mon_d_ff[`ASAM_SCALED_LO_BIT];
	assign hi_en[9]  = mon_d_ff[`ASAM_VOLTAGE_IN_A_HI_BIT];
	assign lo_en[9]  = mon_d_ff[`ASAM_VOLTAGE_IN_A_LO_BIT];
	assign hi_en[10] = 1'b0;
	assign lo_en[10] = 1'b0;
	assign hi_en[11] = 1'b0;
	assign lo_en[11] = 1'b0;
	assign hi_en[16] = mon_a_ff[`ASAM_SENSE_HI_BIT];
	assign lo_en[16] = mon_a_ff[`ASAM_SENSE_LO_BIT];
	assign hi_en[17] = mon_a_ff[`ASAM_SUPPLY_HI_BIT];
	assign lo_en[17] = mon_a_ff[`ASAM_SUPPLY_LO_BIT];
	assign hi_en[18] = mon_a_ff[`ASAM_POWER_HI_BIT];
	assign lo_en[18] = mon_a_ff[`ASAM_POWER_LO_BIT];

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sel_mask_ff <= 19'h70000;
		end else begin
			sel_mask_ff <= sel_mask;
		end
	end

	// ----------------------------------------
	// Conversion sequencer
	// ----------------------------------------
	// Next selected channel after the current one, wrapping
	function automatic asam_chan_t next_sel(input asam_chan_t cur, input logic [18:0] mask);
		asam_chan_t res;
		asam_chan_t idx;
		logic       found;
		res   = `ASAM_CH_SENSE;
		found = 1'b0;
		for (int k = 1; k <= `ASAM_NUM_CH; k++) begin
			idx = 5'((32'(cur) + k) % `ASAM_NUM_CH);
			if (!found && mask[idx]) begin
				res   = idx;
				found = 1'b1;
			end
		end
		return res;
	endfunction

	assign meas_take = (seq_ff == ASAM_WAIT) && i_meas_valid;
	always_comb begin
		nxt_seq  = seq_ff;
		nxt_chan = chan_ff;
		case (seq_ff)
			ASAM_IDLE: begin
				nxt_seq = ASAM_REQ;
			end
			ASAM_REQ: begin
				nxt_seq = ASAM_WAIT;
			end
			ASAM_WAIT: begin
				if (i_meas_valid) begin
					nxt_seq  = ASAM_REQ;
					nxt_chan = next_sel(chan_ff, sel_mask);
				end
			end
			default: begin
				nxt_seq = ASAM_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			seq_ff  <= ASAM_IDLE;
			chan_ff <= `ASAM_CH_SENSE;
			req_ff  <= 1'b0;
		end else begin
			seq_ff  <= nxt_seq;
			chan_ff <= nxt_chan;
			req_ff  <= (nxt_seq == ASAM_REQ);
		end
	end

	// ----------------------------------------
	// Threshold compare
	// ----------------------------------------
	asam_limit_cmp u_cmp (
		.i_value (i_meas_value),
		.i_upper (i_meas_upper),
		.i_lower (i_meas_lower),
		.o_above (above),
		.o_below (below)
	);

	// Channel deselected while in flight raises nothing
	assign thr_hit = meas_take && sel_mask[chan_ff] &&
	                 ((above && hi_en[chan_ff]) || (below && lo_en[chan_ff]));

	// ----------------------------------------
	// Event alerts
	// ----------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			en_prev_ff  <= 1'b1;
			en_known_ff <= 1'b0;
		end else begin
			en_prev_ff  <= i_enable_n;
			en_known_ff <= 1'b1;
		end
	end

	assign fault_hit  = |(i_fault_evt & fault_mask_ff);
	assign pin_hit    = en_known_ff && (i_enable_n != en_prev_ff) && mon_a_ff[`ASAM_EN_PIN_IRQ_BIT];
	assign eeprom_hit = i_eeprom_written && mon_a_ff[`ASAM_EEPROM_IRQ_BIT];
	assign nxt_alert  = thr_hit || fault_hit || pin_hit || eeprom_hit;

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			alert_ff <= 1'b0;
		end else begin
			alert_ff <= nxt_alert;
		end
	end

	// Set wins over a clear in the same cycle
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			seen_ff <= 1'b0;
		end else if (nxt_alert) begin
			seen_ff <= 1'b1;
		end else if (i_alert_clr) begin
			seen_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign o_reg_rdata   = rdata_ff;
	assign o_chan_select = sel_mask_ff;
	assign o_conv_req    = req_ff;
	assign o_conv_chan   = chan_ff;
	assign o_alert       = alert_ff;
	assign o_alert_seen  = seen_ff;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);
	sequence s_meas_done;
		(seq_ff == ASAM_WAIT) && i_meas_valid;
	endsequence
	sequence s_new_req;
		##1 req_ff && (seq_ff == ASAM_REQ);
	endsequence
	single_sel_write_a: assert property (
		i_reg_wr && (i_reg_addr == `ASAM_OFF_SINGLE_SEL) |=> ##1 o_chan_select[7:0] == $past(i_reg_wdata, 2))
		else $error("single select not applied");
	pair_sel_map_a: assert property (
		$past(i_reset_n) |-> o_chan_select[15:12] == $past(pair_sel_ff[7:4]))
		else $error("pair select map wrong");
	voltage_in_a_sel_map_a: assert property (
		$past(i_reset_n) |-> o_chan_select[9:8] == $past(pair_sel_ff[1:0]))
		else $error("voltage_in_a select map wrong");
	readback_path_a: assert property (
		i_reg_rd && !i_reg_wr && (i_reg_addr == `ASAM_OFF_PAIR_SEL) |=> o_reg_rdata == $past(pair_sel_ff))
		else $error("pair select readback wrong");
	fault_gate_a: assert property (
		(i_fault_evt & fault_mask_ff) != 8'h00 |=> o_alert)
		else $error("enabled fault missed");
	no_alert_idle_a: assert property (
		(i_fault_evt & fault_mask_ff) == 8'h00 && !thr_hit && !pin_hit && !eeprom_hit |=> !o_alert)
		else $error("alert without cause");
	eeprom_alert_a: assert property (
		i_eeprom_written && mon_a_ff[`ASAM_EEPROM_IRQ_BIT] |=> o_alert && o_alert_seen)
		else $error("eeprom alert missed");
	deselect_quiet_a: assert property (
		s_meas_done ##0 !sel_mask[chan_ff] ##0 (!fault_hit && !pin_hit && !eeprom_hit)
		|=> !o_alert)
		else $error("alert from deselected input");
	seq_advance_a: assert property (
		s_meas_done |-> s_new_req ##0 sel_mask_ff[o_conv_chan])
		else $error("sequencer did not move to a selected input");
	seen_hold_a: assert property (
		o_alert_seen && !i_alert_clr |=> o_alert_seen)
		else $error("alert status lost without clear");
	seen_clear_a: assert property (
		i_alert_clr && !nxt_alert |=> !o_alert_seen)
		else $error("alert status not cleared");

endmodule

`default_nettype wire

//--- verif/asam_regs_tb_top.sv
// Purpose: Self-checking bench for the select and alert-enable register bank
// Assumes: Inputs change at the falling edge; outputs are read at the falling edge
// Notes:   Second reset mid-run checks reset values after the table loop
`timescale 1ns/1ps
`default_nettype none
`include "asam_map.svh"

module asam_regs_tb_top
	import asam_pkg::*;
();

	typedef struct {
		asam_byte_t a;
		asam_byte_t d;
		asam_byte_t e;
	} asam_tb_row_t;

	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        wr;
	logic        rd;
	logic        mv;
	logic        en_n;
	logic        eew;
	logic        aclr;
	asam_byte_t  addr;
	asam_byte_t  wdata;
	asam_byte_t  fevt;
	asam_meas_t  val;
	asam_meas_t  up;
	asam_meas_t  lo;
	logic [7:0]  rdata;
	logic [18:0] sel;
	logic        req;
	logic [4:0]  ch;
	logic        alert;
	logic        seen;
	int          mismatches;
	int          checked;
	int          cycles;

	asam_tb_row_t rows [9] = '{'{8'h13, 8'hA5, 8'hA5}, '{8'h14, 8'h5E, 8'h5E}, '{8'h15, 8'h3C, 8'h3C},
		'{8'h16, 8'hC3, 8'hC3}, '{8'h17, 8'h96, 8'h96}, '{8'h18, 8'h69, 8'h69}, '{8'h19, 8'h50, 8'h50},
		'{8'h1A, 8'h77, 8'h00}, '{8'h12, 8'h11, 8'h00}};
	asam_byte_t rst_val [7] = '{8'hFF, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	asam_byte_t mset [2][4] = '{'{8'h2A, 8'hAA, 8'hAA, 8'hA0}, '{8'h15, 8'h55, 8'h55, 8'h50}};
	asam_meas_t tv [3] = '{16'h8000, 16'h0001, 16'h1000};
	asam_meas_t tu [3] = '{16'h7FFF, 16'hFFFF, 16'h1000};
	asam_meas_t tl [3] = '{16'h0001, 16'h0002, 16'h1000};

	asam_regs asam_regs_i (
		.i_ref_clk        (clk),
		.i_reset_n        (rst_n),
		.i_reg_wr         (wr),
		.i_reg_rd         (rd),
		.i_reg_addr       (addr),
		.i_reg_wdata      (wdata),
		.o_reg_rdata      (rdata),
		.o_chan_select    (sel),
		.o_conv_req       (req),
		.o_conv_chan      (ch),
		.i_meas_valid     (mv),
		.i_meas_value     (val),
		.i_meas_upper     (up),
		.i_meas_lower     (lo),
		.i_fault_evt      (fevt),
		.i_enable_n       (en_n),
		.i_eeprom_written (eew),
		.i_alert_clr      (aclr),
		.o_alert          (alert),
		.o_alert_seen     (seen)
	);

	always #50 clk = ~clk;

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			results();
		end
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [18:0] sel_of(input asam_byte_t s1, input asam_byte_t s2);
		return {3'b111, s2[7], s2[6], s2[5], s2[4], 2'b00, s2[1], s2[0], s1};
	endfunction

	task automatic results();
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [18:0] exp, input logic [18:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wreg(input asam_byte_t a, input asam_byte_t d);
		wr = 1'b1;
		addr = a;
		wdata = d;
		@(negedge clk);
		wr = 1'b0;
		@(negedge clk);
	endtask

	task automatic rreg(input asam_byte_t a, output asam_byte_t d);
		rd = 1'b1;
		addr = a;
		@(negedge clk);
		rd = 1'b0;
		d = rdata;
		@(negedge clk);
	endtask

	// One cause cycle, then alert and status checked and status cleared
	task automatic cause(input asam_byte_t f, input logic e_n, input logic ee, input logic exp);
		fevt = f;
		en_n = e_n;
		eew = ee;
		@(negedge clk);
		fevt = 8'h00;
		eew = 1'b0;
		chk("alert", 19'(exp), 19'(alert));
		chk("alert_seen", 19'(exp), 19'(seen));
		aclr = 1'b1;
		@(negedge clk);
		aclr = 1'b0;
		chk("alert_seen_clr", 19'h0, 19'(seen));
		@(negedge clk);
	endtask

	task automatic conv(input int k, output logic [4:0] c, output logic a);
		c = ch;
		mv = 1'b1;
		val = tv[k];
		up = tu[k];
		lo = tl[k];
		@(negedge clk);
		mv = 1'b0;
		a = alert;
		chk("conv_req", 19'h1, 19'(req));
		@(negedge clk);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		asam_byte_t d;
		logic [4:0] c;
		logic       a;
		{wr, rd, mv, eew, aclr} = '0;
		en_n = 1'b1;
		{addr, wdata, fevt} = '0;
		{val, up, lo} = '0;
		{mismatches, checked, cycles} = '0;
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		foreach (rows[i]) begin
			wreg(rows[i].a, rows[i].d);
			rreg(rows[i].a, d);
			chk("rdata", 19'(rows[i].e), 19'(d));
		end
		chk("chan_select", sel_of(8'hA5, 8'h5E), sel);
		rst_n = 1'b0;
		@(negedge clk);
		chk("rdata_rst", 19'h0, 19'(rdata));
		chk("select_rst", 19'h70000, sel);
		chk("req_rst", 19'h0, 19'({req, alert, seen}));
		chk("chan_rst", 19'h10, 19'(ch));
		rst_n = 1'b1;
		@(negedge clk);
		chk("chan_select", sel_of(8'hFF, 8'h0F), sel);
		foreach (rst_val[i]) begin
			rreg(8'h13 + 8'(i), d);
			chk("reset_value", 19'(rst_val[i]), 19'(d));
		end
		for (int k = 0; k < 8; k++) begin
			wreg(`ASAM_OFF_FAULT_MASK, 8'h01 << k);
			cause(~(8'h01 << k), en_n, 1'b0, 1'b0);
			cause(8'h01 << k, en_n, 1'b0, 1'b1);
		end
		// Cause and clear in one cycle: set wins, status then holds
		fevt = 8'h80;
		aclr = 1'b1;
		@(negedge clk);
		fevt = 8'h00;
		aclr = 1'b0;
		@(negedge clk);
		chk("seen_set_wins", 19'h1, 19'(seen));
		aclr = 1'b1;
		@(negedge clk);
		aclr = 1'b0;
		chk("seen_clear", 19'h0, 19'(seen));
		wreg(`ASAM_OFF_FAULT_MASK, 8'h00);
		cause(8'h00, 1'b0, 1'b0, 1'b0);
		wreg(`ASAM_OFF_MON_MASK_A, 8'h80);
		cause(8'h00, 1'b1, 1'b0, 1'b1);
		cause(8'h00, 1'b0, 1'b0, 1'b1);
		cause(8'h00, 1'b0, 1'b1, 1'b0);
		wreg(`ASAM_OFF_MON_MASK_A, 8'h40);
		cause(8'h00, 1'b0, 1'b1, 1'b1);
		cause(8'h00, 1'b1, 1'b0, 1'b0);
		wreg(`ASAM_OFF_PAIR_SEL, 8'hFF);
		// Enable sets: high-only, then low-only; values above, below, equal
		for (int m = 0; m < 2; m++) begin
			for (int r = 0; r < 4; r++) begin
				wreg(8'h16 + 8'(r), mset[m][r]);
			end
			for (int j = 0; j < 3; j++) begin
				for (int n = 0; n < 19; n++) begin
					conv(j, c, a);
					chk("limit_alert", 19'(j == m && !(c >= 12 && c <= 15)), 19'(a));
				end
			end
		end
		wreg(`ASAM_OFF_SINGLE_SEL, 8'h00);
		wreg(`ASAM_OFF_PAIR_SEL, 8'h0C);
		chk("chan_select", 19'h70000, sel);
		for (int n = 0; n < 6; n++) begin
			conv(1, c, a);
			chk("skip_alert", 19'(c >= 16), 19'(a));
			if (n > 0) begin
				chk("skip_chan", 19'h1, 19'(c >= 16));
			end
		end
		results();
	end

endmodule

`default_nettype wire
